/* src/lsc_pkg.sv */
// shared constants for the led sink power and fault control block
package lsc_pkg;
  localparam int          NUM_CH          = 48;
  localparam int          NUM_GROUPS      = 12;
  localparam int          CH_PER_GROUP    = NUM_CH / NUM_GROUPS;
  localparam int          GS_W            = 16;
  localparam int          FC2_W           = 8;
  localparam int          FC2_PSAVE_BIT   = 5;
  localparam logic [7:0]  FC2_RESET       = 8'h00;
  localparam int          THR_W           = 2;
  localparam logic [1:0]  THR_RESET       = 2'h0;
  // grayscale clock rate and stagger delay between groups
  localparam int          CLK_MHZ         = 125;
  localparam int          GROUP_DELAY_NS  = 16;
  localparam int          GROUP_DELAY_CYC =
    (GROUP_DELAY_NS * CLK_MHZ + 999) / 1000 < 1 ? 1 :
    (GROUP_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int          STG_W           = 4;
  localparam logic [3:0]  STG_DONE        = 4'hc;
  localparam logic [3:0]  STG_ZERO        = 4'h0;
  typedef enum logic [0:0] {LSC_NORMAL, LSC_SAVE} lsc_mode_t;
endpackage

/* src/lsc_sync2.sv */
// two flip-flop synchroniser for a bus of asynchronous levels
`timescale 1ns/1ps
module lsc_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule

/* src/lsc_top.sv */
// control logic of a multiplexed constant-current led sink driver
// Notes on behaviour
// - open flag is 1 when output voltage below selected threshold, else 0.
// - open flag valid only during channel on period; off channels report 0.
// - power save allowed only when second control bit 5 set; resets 0.
// - enter power save at frame sync if next frame data all zero.
// - leave power save on any non-zero grayscale data input.
// - in power save, sink outputs and open detection are disabled.
// - 48 channels in 12 groups switch on one after another, delayed.
// - pre-charge pull-up on only during common line switching interval.
// - over-temperature forces all outputs off until indication clears.
// - reference short turns all outputs off until voltage recovers.
// - frame sync displays just-written bank and swaps the two banks.
`timescale 1ns/1ps
module lsc_top (
  input  wire logic                    CLK_I,
  input  wire logic                    RST_I,
  input  wire logic                    FC2_WR_I,
  input  wire logic [7:0]              FC2_DATA_I,
  input  wire logic                    THR_WR_I,
  input  wire logic [1:0]              THR_DATA_I,
  input  wire logic                    GS_VALID_I,
  input  wire logic [15:0]             GS_DATA_I,
  input  wire logic                    FRAME_SYNC_I,
  input  wire logic                    SEG_START_I,
  input  wire logic                    LINE_SWITCH_I,
  input  wire logic [47:0]             CH_PWM_ON_I,
  input  wire logic [47:0]             OPEN_CMP_I,
  input  wire logic                    THERMAL_CUTOFF_I,
  input  wire logic                    REFERENCE_SHORT_GUARD_I,
  output logic      [47:0]             SINK_OUTPUT_EN_O,
  output logic      [47:0]             OPEN_LED_FLAG_O,
  output logic                         POWER_SAVE_STATE_O,
  output logic                         PRECHARGE_EN_O,
  output logic                         DISPLAY_BANK_O,
  output logic      [7:0]              FUNCTION_CONTROL_SECOND_O,
  output logic      [1:0]              OPEN_DETECT_THRESHOLD_SEL_O
);
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] DLY_LAST =
    CNT_W'(lsc_pkg::GROUP_DELAY_CYC - 1);

  // configuration registers
  logic [7:0]             function_control_second;
  logic [1:0]             open_detect_threshold_sel;
  // synchronised analog indications
  logic [47:0]            open_cmp_s;
  logic [1:0]             fault_s;
  // power save and frame tracking
  lsc_pkg::lsc_mode_t     mode;
  logic                   frame_all_zero;
  logic                   display_bank;
  // stagger
  logic [3:0]             stage;
  logic [CNT_W-1:0]       dly_cnt;

  wire power_save_enable = function_control_second[lsc_pkg::FC2_PSAVE_BIT];
  wire gs_nonzero        = GS_VALID_I && (GS_DATA_I != 16'h0000);
  wire fault_off         = fault_s[0] | fault_s[1];
  wire in_save           = (mode == lsc_pkg::LSC_SAVE);
  wire stage_done        = (stage == lsc_pkg::STG_DONE);
  wire stage_step        = !stage_done && (dly_cnt == DLY_LAST);

  lsc_sync2 #(.W(48)) u_open_sync (
    .clk_i (CLK_I),
    .rst_i (RST_I),
    .d_i   (OPEN_CMP_I),
    .q_o   (open_cmp_s)
  );
  lsc_sync2 #(.W(2)) u_fault_sync (
    .clk_i (CLK_I),
    .rst_i (RST_I),
    .d_i   ({REFERENCE_SHORT_GUARD_I, THERMAL_CUTOFF_I}),
    .q_o   (fault_s)
  );

  // second control register resets to zero
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      function_control_second   <= lsc_pkg::FC2_RESET;
      open_detect_threshold_sel <= lsc_pkg::THR_RESET;
    end else begin
      if (FC2_WR_I) function_control_second <= FC2_DATA_I;
      if (THR_WR_I) open_detect_threshold_sel <= THR_DATA_I;
    end
  end

  // zero tracking of grayscale data for next frame
  wire next_frame_all_zero = FRAME_SYNC_I ? !gs_nonzero :
                             (frame_all_zero && !gs_nonzero);

  // enter at frame sync; leave on non-zero data
  lsc_pkg::lsc_mode_t next_mode;
  always_comb begin
    next_mode = mode;
    unique case (mode)
      lsc_pkg::LSC_NORMAL:
        if (FRAME_SYNC_I && power_save_enable && frame_all_zero &&
            !gs_nonzero) begin
          next_mode = lsc_pkg::LSC_SAVE;
        end
      lsc_pkg::LSC_SAVE:
        if (gs_nonzero || !power_save_enable) begin
          next_mode = lsc_pkg::LSC_NORMAL;
        end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      mode           <= lsc_pkg::LSC_NORMAL;
      frame_all_zero <= 1'b1;
      display_bank   <= 1'b0;
    end else begin
      mode           <= next_mode;
      frame_all_zero <= next_frame_all_zero;
      if (FRAME_SYNC_I) display_bank <= ~display_bank;
    end
  end

  // group stagger restarts at each segment start
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      stage   <= lsc_pkg::STG_ZERO;
      dly_cnt <= '0;
    end else if (SEG_START_I) begin
      stage   <= 4'h1;
      dly_cnt <= '0;
    end else if (stage_step) begin
      stage   <= stage + 4'h1;
      dly_cnt <= '0;
    end else if (!stage_done && stage != lsc_pkg::STG_ZERO) begin
      dly_cnt <= dly_cnt + CNT_W'(1);
    end
  end

  logic [47:0] group_allow;
  always_comb begin
    group_allow = '0;
    for (int g = 0; g < lsc_pkg::NUM_GROUPS; g++) begin
      for (int c = 0; c < lsc_pkg::CH_PER_GROUP; c++) begin
        group_allow[g*lsc_pkg::CH_PER_GROUP + c] = (stage > 4'(g));
      end
    end
  end

  wire         outputs_ok = !in_save && !fault_off;
  wire [47:0]  next_sink  = outputs_ok ? (CH_PWM_ON_I & group_allow) : '0;
  // flags only for channels driven on
  wire [47:0]  next_flag  = outputs_ok ? (open_cmp_s & SINK_OUTPUT_EN_O) : '0;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      SINK_OUTPUT_EN_O            <= '0;
      OPEN_LED_FLAG_O             <= '0;
      POWER_SAVE_STATE_O          <= 1'b0;
      PRECHARGE_EN_O              <= 1'b0;
      DISPLAY_BANK_O              <= 1'b0;
      FUNCTION_CONTROL_SECOND_O   <= lsc_pkg::FC2_RESET;
      OPEN_DETECT_THRESHOLD_SEL_O <= lsc_pkg::THR_RESET;
    end else begin
      SINK_OUTPUT_EN_O            <= next_sink;
      OPEN_LED_FLAG_O             <= next_flag;
      POWER_SAVE_STATE_O          <= in_save;
      PRECHARGE_EN_O              <= LINE_SWITCH_I;
      DISPLAY_BANK_O              <= display_bank;
      FUNCTION_CONTROL_SECOND_O   <= function_control_second;
      OPEN_DETECT_THRESHOLD_SEL_O <= open_detect_threshold_sel;
    end
  end

  // stagger and wake-up steps
  sequence seg_kick;
    SEG_START_I;
  endsequence
  sequence first_group_only;
    stage == 4'h1 ##1 (group_allow[47:4] == '0);
  endsequence
  sequence save_wake;
    in_save && gs_nonzero;
  endsequence
  sequence state_out_drops;
    !in_save ##1 !POWER_SAVE_STATE_O;
  endsequence

  chk_psave_needs_en: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    $rose(in_save) |-> $past(power_save_enable))
    else $error("power save entered while disabled");
  chk_config_reset: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    $past(RST_I) |-> FUNCTION_CONTROL_SECOND_O == lsc_pkg::FC2_RESET &&
      !power_save_enable)
    else $error("control register not cleared by reset");
  chk_psave_entry: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    $rose(in_save) |-> $past(FRAME_SYNC_I))
    else $error("power save entered outside frame sync");
  chk_entry_blocked: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    !frame_all_zero && !in_save |=> !in_save)
    else $error("power save entered after non-zero data");
  chk_zero_cleared: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    gs_nonzero |=> !frame_all_zero)
    else $error("non-zero data not remembered");
  chk_zero_rearm: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    FRAME_SYNC_I && !gs_nonzero |=> frame_all_zero)
    else $error("zero tracking not restarted");
  chk_state_output: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    !$past(RST_I) |-> POWER_SAVE_STATE_O == $past(in_save))
    else $error("power save state output stale");
  chk_psave_exit: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    in_save && gs_nonzero |=> !in_save)
    else $error("power save not left on data");
  chk_wake_output: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    save_wake |=> state_out_drops)
    else $error("wake-up not shown on state output");
  chk_save_gates: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    in_save |=> SINK_OUTPUT_EN_O == '0 && OPEN_LED_FLAG_O == '0)
    else $error("outputs active in power save");
  chk_fault_off: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    fault_off |=> SINK_OUTPUT_EN_O == '0)
    else $error("outputs on during fault");
  chk_thermal_flags: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    fault_s[0] |=> OPEN_LED_FLAG_O == '0)
    else $error("flags active during thermal cutoff");
  chk_short_gates: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    fault_s[1] |=> SINK_OUTPUT_EN_O == '0 && OPEN_LED_FLAG_O == '0)
    else $error("outputs active during reference short");
  chk_flag_on_only: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    (OPEN_LED_FLAG_O & ~$past(SINK_OUTPUT_EN_O)) == '0)
    else $error("flag on off channel");
  chk_group_order: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    seg_kick |=> first_group_only)
    else $error("groups not staggered");
  chk_stage_advance: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    stage_step && !SEG_START_I |=> stage == $past(stage) + 4'h1)
    else $error("stagger skipped a group");
  chk_stage_gap: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    stage_step && !SEG_START_I |=> !stage_step)
    else $error("groups switched without delay");
  chk_stage_bound: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    stage <= lsc_pkg::STG_DONE)
    else $error("stagger stage out of range");
  chk_stage_idle: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    stage == lsc_pkg::STG_ZERO && !SEG_START_I |=>
      stage == lsc_pkg::STG_ZERO)
    else $error("stagger started without segment start");
  chk_sink_allowed: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    (SINK_OUTPUT_EN_O & ~$past(group_allow)) == '0)
    else $error("sink on before its group");
  chk_precharge: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    !$past(RST_I) |-> PRECHARGE_EN_O == $past(LINE_SWITCH_I))
    else $error("precharge outside switching");
  chk_bank_swap: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    FRAME_SYNC_I |=> display_bank != $past(display_bank))
    else $error("bank not swapped");
  chk_bank_hold: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    !FRAME_SYNC_I |=> display_bank == $past(display_bank))
    else $error("bank changed without frame sync");
  chk_open_sync: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    !$past(RST_I) && !$past(RST_I, 2) |->
      open_cmp_s == $past(OPEN_CMP_I, 2))
    else $error("open comparator not synchronised");
  chk_fault_sync: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    !$past(RST_I) && !$past(RST_I, 2) |->
      fault_s == $past({REFERENCE_SHORT_GUARD_I, THERMAL_CUTOFF_I}, 2))
    else $error("fault input not synchronised");
endmodule

/* verification/lsc_ctrl_model.sv */
// display controller model: control writes, grayscale words, frame sync
`timescale 1ns/1ps
module lsc_ctrl_model (
  input  wire logic        clk_i,
  output logic             fc2_wr_o,
  output logic [7:0]       fc2_data_o,
  output logic             gs_valid_o,
  output logic [15:0]      gs_data_o,
  output logic             frame_sync_o
);
  localparam logic [2:0] global_brightness_code = 3'h4;
  // strongest group gets the full color code
  localparam logic [8:0] red_color_code         = 9'h1ff;
  initial begin
    fc2_wr_o = 1'b0;
    fc2_data_o = 8'h5a;
    gs_valid_o = 1'b0;
    gs_data_o = 16'h5a5a;
    frame_sync_o = 1'b0;
  end
  task automatic put_fc2(input logic [7:0] d);
    @(posedge clk_i);
    fc2_wr_o <= 1'b1;
    fc2_data_o <= d;
    @(posedge clk_i);
    fc2_wr_o <= 1'b0;
    fc2_data_o <= ~d;
  endtask
  // idle data shows the inverse, so it must be ignored without valid
  task automatic put_gs(input logic [15:0] d);
    @(posedge clk_i);
    gs_valid_o <= 1'b1;
    gs_data_o <= d;
    @(posedge clk_i);
    gs_valid_o <= 1'b0;
    gs_data_o <= ~d;
  endtask
  task automatic sync();
    @(posedge clk_i);
    frame_sync_o <= 1'b1;
    @(posedge clk_i);
    frame_sync_o <= 1'b0;
  endtask
endmodule

/* verification/lsc_top_tb_top.sv */
// self-checking bench for the led sink power and fault control block
`timescale 1ns/1ps
module lsc_top_tb_top;
  logic        clk = 1'b0, rst = 1'b1, thr_wr = 1'b0, seg = 1'b0;
  logic        line_sw = 1'b0, tc = 1'b0, rs = 1'b0;
  logic [1:0]  thr_data = 2'h0;
  logic [47:0] pwm = 48'h0, opn = 48'h0, allow = 48'h0;
  logic        fc2_wr, gs_valid, fsync, ps_o, pre_o, bank_o;
  logic [7:0]  fc2_data, fc2_o;
  logic [15:0] gs_data;
  logic [47:0] sink, flag;
  logic [1:0]  thr_o;
  logic [31:0] r;
  integer      seed = 69838;
  int          miscompares = 0, samples_checked = 0, cycles = 0;
  int          ps = 0, bank = 0, fc2 = 0, thr = 0;
  lsc_ctrl_model m (.clk_i(clk), .fc2_wr_o(fc2_wr), .fc2_data_o(fc2_data),
    .gs_valid_o(gs_valid), .gs_data_o(gs_data), .frame_sync_o(fsync));
  lsc_top dut (.CLK_I(clk), .RST_I(rst), .FC2_WR_I(fc2_wr),
    .FC2_DATA_I(fc2_data), .THR_WR_I(thr_wr), .THR_DATA_I(thr_data),
    .GS_VALID_I(gs_valid), .GS_DATA_I(gs_data), .FRAME_SYNC_I(fsync),
    .SEG_START_I(seg), .LINE_SWITCH_I(line_sw), .CH_PWM_ON_I(pwm),
    .OPEN_CMP_I(opn), .THERMAL_CUTOFF_I(tc), .REFERENCE_SHORT_GUARD_I(rs),
    .SINK_OUTPUT_EN_O(sink), .OPEN_LED_FLAG_O(flag),
    .POWER_SAVE_STATE_O(ps_o), .PRECHARGE_EN_O(pre_o),
    .DISPLAY_BANK_O(bank_o), .FUNCTION_CONTROL_SECOND_O(fc2_o),
    .OPEN_DETECT_THRESHOLD_SEL_O(thr_o));
  always #4 clk = ~clk;
  task automatic summarize();
    if (miscompares == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // inputs held steady long enough to pass the synchronisers
  task automatic check();
    repeat (6) @(posedge clk);
    #1;
    cmp(sink, (tc | rs | ps != 0) ? 48'h0 : (pwm & allow));
    cmp(flag, (tc | rs | ps != 0) ? 48'h0 : (opn & pwm & allow));
    cmp(48'(ps_o), 48'(ps));
    cmp(48'(pre_o), 48'(line_sw));
    cmp(48'(bank_o), 48'(bank));
    cmp(48'(fc2_o), 48'(fc2));
    cmp(48'(thr_o), 48'(thr));
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    pwm <= 48'hffff_ffff_ffff;
    check();
    @(posedge clk);
    seg <= 1'b1;
    @(posedge clk);
    seg <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    cmp({sink[47:44], sink[3:0]}, 48'h0f);
    repeat (30) @(posedge clk);
    allow = 48'hffff_ffff_ffff;
    for (int i = 0; i < 24; i++) begin
      r = $random(seed);
      @(posedge clk);
      pwm <= 48'({$random(seed), $random(seed)});
      opn <= 48'({$random(seed), $random(seed)});
      tc <= r[0] & r[1];
      rs <= r[2] & r[3];
      line_sw <= r[4];
      thr_wr <= 1'b1;
      thr_data <= r[6:5];
      thr = r[6:5];
      @(posedge clk);
      thr_wr <= 1'b0;
      fc2 = r[15:8] & 8'hdf;
      m.put_fc2(r[15:8] & 8'hdf);
      check();
    end
    @(posedge clk);
    tc <= 1'b0;
    rs <= 1'b0;
    fc2 = 8'h20;
    m.put_fc2(8'h20);
    m.put_gs(16'h0000);
    m.sync();
    ps = 1;
    bank ^= 1;
    check();
    m.put_gs(16'h0001);
    ps = 0;
    check();
    m.sync();
    bank ^= 1;
    check();
    fc2 = 8'h20;
    m.put_fc2(8'h20);
    m.sync();
    ps = 1;
    bank ^= 1;
    check();
    fc2 = 8'h00;
    m.put_fc2(8'h00);
    ps = 0;
    check();
    m.put_gs(16'h0000);
    m.sync();
    bank ^= 1;
    check();
    summarize();
  end
endmodule
